// File: inc/tmrb_pkg.sv
// constants, register map and carrier types of the sixteen-bit timer/counter
package tmrb_pkg;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [11:0] TMRB_OFS_COUNT_LOW  = 12'h000;
  localparam logic [11:0] TMRB_OFS_COUNT_HIGH = 12'h004;
  localparam logic [11:0] TMRB_OFS_CONTROL    = 12'h008;
  localparam logic [11:0] TMRB_OFS_FLAG       = 12'h00C;
  localparam logic [11:0] TMRB_OFS_ENABLE     = 12'h010;

  // control register field positions
  localparam int TMRB_BIT_WIDE    = 7;
  localparam int TMRB_BIT_PRE_HI  = 5;
  localparam int TMRB_BIT_PRE_LO  = 4;
  localparam int TMRB_BIT_OSC     = 3;
  localparam int TMRB_BIT_NOSYNC  = 2;
  localparam int TMRB_BIT_SOURCE  = 1;
  localparam int TMRB_BIT_RUN     = 0;

  // writable bits of the control register; bit 6 does not exist
  localparam logic [7:0] TMRB_CTRL_WMASK = 8'hBF;
  localparam logic [7:0] TMRB_CTRL_RESET = 8'h00;

  // flag and enable bit position in their registers
  localparam int TMRB_BIT_OVF = 0;

  // prescale field encodings
  localparam logic [1:0] TMRB_PRE_DIV1 = 2'h0;
  localparam logic [1:0] TMRB_PRE_DIV2 = 2'h1;
  localparam logic [1:0] TMRB_PRE_DIV4 = 2'h2;
  localparam logic [1:0] TMRB_PRE_DIV8 = 2'h3;

  // prescaler masks: a step is released when all masked bits are one
  localparam logic [2:0] TMRB_MASK_DIV1 = 3'h0;
  localparam logic [2:0] TMRB_MASK_DIV2 = 3'h1;
  localparam logic [2:0] TMRB_MASK_DIV4 = 3'h3;
  localparam logic [2:0] TMRB_MASK_DIV8 = 3'h7;

  // instruction cycle is four system clocks
  localparam logic [1:0] TMRB_PHASE_LAST = 2'h3;

  // count value at which the next step wraps
  localparam logic [15:0] TMRB_COUNT_MAX = 16'hFFFF;

  // operating modes
  typedef enum logic [1:0] {
    TMRB_TIMER,
    TMRB_SYNC_COUNTER,
    TMRB_ASYNC_COUNTER
  } tmrb_mode_type;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } tmrb_apb_req_type;

  // whole state of the block
  typedef struct packed {
    logic        syncFirst;
    logic        syncSecond;
    logic        syncPrev;
    logic [1:0]  phase;
    logic [2:0]  prescale;
    logic [7:0]  countLow;
    logic [7:0]  countHigh;
    logic [7:0]  highBuffer;
    logic [7:0]  control;
    logic        overflowFlag;
    logic        overflowIrqEnable;
    logic [31:0] readData;
  } tmrb_state_type;

  localparam tmrb_state_type TMRB_STATE_RESET = '{
    syncFirst: 1'b0, syncSecond: 1'b0, syncPrev: 1'b0, phase: 2'h0,
    prescale: 3'h0, countLow: 8'h00, countHigh: 8'h00, highBuffer: 8'h00,
    control: TMRB_CTRL_RESET, overflowFlag: 1'b0, overflowIrqEnable: 1'b0,
    readData: 32'h00000000};

endpackage : tmrb_pkg

// File: verilog/tmrb_timer_counter.sv
// sixteen-bit timer/counter with apb register access
//
// The implementer's own choices: the placing of the registers and the APB slave port.
module tmrb_timer_counter
  import tmrb_pkg::*;
(
  input  wire logic             clk,                 // system clock
  input  wire logic             sys_rst,             // synchronous reset, high
  input  wire tmrb_apb_req_type apbReq,              // apb request signals
  output logic [31:0]           prdata,              // read data, registered
  output logic                  pready,              // always ready
  output logic                  pslverr,             // unmapped address
  input  wire logic             specialEventTrigger, // compare unit reset pulse
  input  wire logic [1:0]       pinIn,               // pin levels, bit 0 count pin
  input  wire logic [1:0]       portDataOut,         // port data for the pins
  input  wire logic [1:0]       portCDirection,      // port direction, 1 = input
  output logic [1:0]            pinOut,              // pin output value
  output logic [1:0]            pinOeN,              // pin drive enable, low drives
  output logic                  oscAmpEnable,        // crystal amplifier power
  output logic [15:0]           countValue,          // live count for compare unit
  output logic                  overflowIrq          // gated overflow request
);

  tmrb_state_type st;        // registered state
  tmrb_state_type next_st;   // next state

  // decoded helpers
  tmrb_mode_type  mode;          // current operating mode
  logic           extRise;       // synchronised rising edge of count pin
  logic           instrTick;     // one pulse per instruction cycle
  logic           srcTick;       // selected count input pulse
  logic [2:0]     preMask;       // prescaler release mask
  logic           stepCount;     // count advances this cycle
  logic           wrapEvent;     // step from all ones
  logic [15:0]    countNext;     // incremented count
  logic           setupPhase;    // apb setup cycle
  logic           accessPhase;   // apb access cycle
  logic           mapped;        // address hits a register
  logic           doWrite;       // write takes effect now
  logic           laneLow;       // byte lane 0 written
  logic           wide;          // wide access mode
  logic [7:0]     wbyte;         // written byte

  // bus phase and address decode
  always_comb begin
    setupPhase  = apbReq.psel & ~apbReq.penable;
    accessPhase = apbReq.psel & apbReq.penable;
    mapped = (apbReq.paddr == TMRB_OFS_COUNT_LOW) || (apbReq.paddr == TMRB_OFS_COUNT_HIGH) ||
             (apbReq.paddr == TMRB_OFS_CONTROL) || (apbReq.paddr == TMRB_OFS_FLAG) ||
             (apbReq.paddr == TMRB_OFS_ENABLE);
    doWrite = accessPhase & apbReq.pwrite & mapped;
    laneLow = apbReq.pstrb[0];
    wbyte   = apbReq.pwdata[7:0];
    wide    = st.control[TMRB_BIT_WIDE];
  end

  // mode decode from source and sync bits
  always_comb begin
    if (!st.control[TMRB_BIT_SOURCE]) begin
      mode = TMRB_TIMER;
    end else if (st.control[TMRB_BIT_NOSYNC]) begin
      mode = TMRB_ASYNC_COUNTER;
    end else begin
      mode = TMRB_SYNC_COUNTER;
    end
  end

  // prescale ratio select
  always_comb begin
    case (st.control[TMRB_BIT_PRE_HI:TMRB_BIT_PRE_LO])
      TMRB_PRE_DIV1: preMask = TMRB_MASK_DIV1;
      TMRB_PRE_DIV2: preMask = TMRB_MASK_DIV2;
      TMRB_PRE_DIV4: preMask = TMRB_MASK_DIV4;
      TMRB_PRE_DIV8: preMask = TMRB_MASK_DIV8;
      default:       preMask = TMRB_MASK_DIV1;
    endcase
  end

  // next state: sync chain, prescaler, count, registers
  always_comb begin
    next_st = st;

    // pin edge finder; first stage only feeds the second
    next_st.syncFirst  = pinIn[0];
    next_st.syncSecond = st.syncFirst;
    next_st.syncPrev   = st.syncSecond;
    extRise = st.syncSecond & ~st.syncPrev;

    // quarter-rate instruction tick
    next_st.phase = st.phase + 2'h1;
    instrTick     = (st.phase == TMRB_PHASE_LAST);

    // source select; crystal output and count pin share pin 0
    case (mode)
      TMRB_TIMER:         srcTick = instrTick;
      TMRB_SYNC_COUNTER:  srcTick = extRise;
      TMRB_ASYNC_COUNTER: srcTick = extRise;
      default:            srcTick = 1'b0;
    endcase

    // prescaler and count step, only while running
    stepCount = 1'b0;
    if (st.control[TMRB_BIT_RUN] && srcTick) begin
      if ((st.prescale & preMask) == preMask) begin
        stepCount        = 1'b1;
        next_st.prescale = 3'h0;
      end else begin
        next_st.prescale = st.prescale + 3'h1;
      end
    end
    countNext = {st.countHigh, st.countLow} + 16'h0001;
    wrapEvent = stepCount && ({st.countHigh, st.countLow} == TMRB_COUNT_MAX);
    if (stepCount) begin
      {next_st.countHigh, next_st.countLow} = countNext;
    end

    // compare trigger clears count; unreliable in async mode so ignored there
    if (specialEventTrigger && (mode != TMRB_ASYNC_COUNTER)) begin
      next_st.countHigh = 8'h00;
      next_st.countLow  = 8'h00;
      wrapEvent         = 1'b0;
    end

    // register writes, after the trigger so a write wins
    if (doWrite && laneLow) begin
      case (apbReq.paddr)
        TMRB_OFS_COUNT_LOW: begin
          next_st.countLow = wbyte;
          next_st.prescale = 3'h0;
          if (wide) begin
            next_st.countHigh = st.highBuffer;
          end
          wrapEvent = 1'b0;
        end
        TMRB_OFS_COUNT_HIGH: begin
          if (wide) begin
            next_st.highBuffer = wbyte;
          end else begin
            next_st.countHigh = wbyte;
            next_st.prescale  = 3'h0;
            wrapEvent         = 1'b0;
          end
        end
        TMRB_OFS_CONTROL: begin
          next_st.control = wbyte & TMRB_CTRL_WMASK;
        end
        TMRB_OFS_FLAG: begin
          next_st.overflowFlag = wbyte[TMRB_BIT_OVF];
        end
        TMRB_OFS_ENABLE: begin
          next_st.overflowIrqEnable = wbyte[TMRB_BIT_OVF];
        end
        default: begin
          next_st.control = st.control;
        end
      endcase
    end

    // hardware set beats a software clear in the same cycle
    if (wrapEvent) begin
      next_st.overflowFlag = 1'b1;
    end

    // read data captured in the setup cycle, together with the buffer copy
    if (setupPhase && !apbReq.pwrite) begin
      case (apbReq.paddr)
        TMRB_OFS_COUNT_LOW: begin
          next_st.readData = {24'h000000, st.countLow};
          if (wide) begin
            next_st.highBuffer = st.countHigh;
          end
        end
        TMRB_OFS_COUNT_HIGH: begin
          next_st.readData = {24'h000000, wide ? st.highBuffer : st.countHigh};
        end
        TMRB_OFS_CONTROL: begin
          next_st.readData = {24'h000000, st.control & TMRB_CTRL_WMASK};
        end
        TMRB_OFS_FLAG: begin
          next_st.readData = {31'h00000000, st.overflowFlag};
        end
        TMRB_OFS_ENABLE: begin
          next_st.readData = {31'h00000000, st.overflowIrqEnable};
        end
        default: begin
          next_st.readData = 32'h00000000;
        end
      endcase
    end
  end

  // single state register; reset clears all control bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= TMRB_STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // bus answer: zero wait states, error on unmapped words
  assign prdata  = st.readData;
  assign pready  = 1'b1;
  assign pslverr = accessPhase & ~mapped;

  // oscillator power follows its enable bit
  assign oscAmpEnable = st.control[TMRB_BIT_OSC];

  // pins become inputs whenever the oscillator owns them
  assign pinOut = portDataOut;
  assign pinOeN = st.control[TMRB_BIT_OSC] ? 2'h3 : portCDirection;

  // count to the compare unit and gated overflow request
  assign countValue  = {st.countHigh, st.countLow};
  assign overflowIrq = st.overflowFlag & st.overflowIrqEnable;

endmodule : tmrb_timer_counter

// File: test/tmrb_count_source.sv
// external count source: square wave on the count pin while running
module tmrb_count_source (
  input  wire logic       run,  // frame enable from the bench
  output logic      [1:0] pins  // bit 0 count pin, bit 1 crystal input
);
  timeunit 1ns;
  timeprecision 1ps;
  // 160 ns period, offset so edges never meet the 20 ns clock edges
  initial begin
    pins = 2'b10;
    #7;
    forever begin
      #80;
      // stands still low between frames, like a gated source
      pins = run ? ~pins : 2'b10;
    end
  end
endmodule : tmrb_count_source

// File: test/tmrb_timer_counter_assertions.sv
// port checker of the timer/counter, bound to the top module
module tmrb_timer_counter_checker
  import tmrb_pkg::*;
(
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire tmrb_apb_req_type apbReq,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             specialEventTrigger,
  input wire logic [1:0]       pinIn,
  input wire logic [1:0]       portDataOut,
  input wire logic [1:0]       portCDirection,
  input wire logic [1:0]       pinOut,
  input wire logic [1:0]       pinOeN,
  input wire logic             oscAmpEnable,
  input wire logic [15:0]      countValue,
  input wire logic             overflowIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  // single domain, so one clock and one disable for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  pins_forced_a: assert property (oscAmpEnable |-> pinOeN == 2'b11)
    else $error("pins driven while crystal on");
  pins_follow_a: assert property (!oscAmpEnable |-> pinOeN == portCDirection)
    else $error("pin enables ignore port direction");
  wrap_flag_a: assert property (($rose(overflowIrq) && !$past(apbReq.psel))
    |-> countValue == 16'h0000 && $past(countValue) == 16'hFFFF)
    else $error("overflow without wrap");
  single_step_a: assert property ((!$past(apbReq.psel) && !$past(specialEventTrigger))
    |-> countValue == $past(countValue) || countValue == $past(countValue) + 16'h0001)
    else $error("count jumped");
  step_spacing_a: assert property (($changed(countValue) && !$past(apbReq.psel)
    && !$past(specialEventTrigger)) |=> $stable(countValue) || $past(apbReq.psel)
    || $past(specialEventTrigger)) else $error("steps too close");
  bit6_zero_a: assert property ((apbReq.psel && apbReq.penable && !apbReq.pwrite
    && apbReq.paddr == TMRB_OFS_CONTROL) |-> prdata[31:6] == 26'h0 || prdata[31:6] == 26'h2)
    else $error("control bit 6 reads one");
  flag_latched_a: assert property ($fell(overflowIrq) |-> $past(apbReq.psel))
    else $error("flag dropped by itself");
  osc_write_a: assert property ($changed(oscAmpEnable) |-> $past(apbReq.psel
    && apbReq.pwrite && apbReq.paddr == TMRB_OFS_CONTROL)) else $error("osc power changed");
endmodule : tmrb_timer_counter_checker

bind tmrb_timer_counter tmrb_timer_counter_checker u_checker (.clk(clk), .sys_rst(sys_rst),
  .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .specialEventTrigger(specialEventTrigger), .pinIn(pinIn), .portDataOut(portDataOut),
  .portCDirection(portCDirection), .pinOut(pinOut), .pinOeN(pinOeN),
  .oscAmpEnable(oscAmpEnable), .countValue(countValue), .overflowIrq(overflowIrq));

// File: test/tmrb_timer_counter_tb.sv
// self-checking bench of the timer/counter
module tmrb_timer_counter_tb
  import tmrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0;     // 50 MHz system clock
  logic             sys_rst = 1'b1; // held for ten cycles
  tmrb_apb_req_type apbReq = '0;    // bus request
  logic [31:0]      prdata;
  logic             pready, pslverr, oscAmpEnable, overflowIrq;
  logic             trig = 1'b0;    // compare unit pulse
  logic             srcRun = 1'b0;  // external source frame
  logic [1:0]       portDir = 2'b10;  // port direction, changed per scenario
  logic [1:0]       portData = 2'b01; // port data, changed per scenario
  logic [1:0]       pinIn, pinOut, pinOeN;
  logic [15:0]      countValue;
  logic [31:0]      rd;             // last read data
  logic             err;            // last error response
  int               num_errors = 0;
  int               checks = 0;
  int               cycles = 0;
  always #10 clk = ~clk;
  tmrb_timer_counter u_dut (.clk(clk), .sys_rst(sys_rst), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .specialEventTrigger(trig), .pinIn(pinIn),
    .portDataOut(portData), .portCDirection(portDir), .pinOut(pinOut), .pinOeN(pinOeN),
    .oscAmpEnable(oscAmpEnable), .countValue(countValue), .overflowIrq(overflowIrq));
  tmrb_count_source u_src (.run(srcRun), .pins(pinIn));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; trg pulses the compare trigger in the access cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic trg);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: 4'hF};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    trig <= trg;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    trig <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic tally_and_finish;
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // control reset value, missing bit and an unmapped place
  task automatic t_regs;
    apb(0, TMRB_OFS_CONTROL, 0, 0);
    check(rd, 32'h0);
    apb(1, TMRB_OFS_CONTROL, 32'hFF, 0);
    apb(0, TMRB_OFS_CONTROL, 0, 0);
    check(rd, 32'hBF);
    apb(1, TMRB_OFS_CONTROL, 0, 0);
    apb(0, 12'h020, 0, 0);
    check({rd[31:1], err}, 32'h1);
  endtask : t_regs
  // internal source at every prescale, sync bit set but ignored
  task automatic t_timer;
    int          e;
    logic [31:0] hold;
    for (int p = 0; p < 4; p++) begin
      apb(1, TMRB_OFS_COUNT_LOW, 0, 0);
      apb(1, TMRB_OFS_CONTROL, 32'(p << 4) | 32'h05, 0);
      repeat (256) @(posedge clk);
      apb(1, TMRB_OFS_CONTROL, 0, 0);
      apb(0, TMRB_OFS_COUNT_LOW, 0, 0);
      e = 64 >> p;
      check(32'(rd >= e && rd <= e + 1), 32'h1);
      hold = rd;
      repeat (40) @(posedge clk);
      apb(0, TMRB_OFS_COUNT_LOW, 0, 0);
      check(rd, hold);
    end
  endtask : t_timer
  // external edges, unsynchronised and then synchronised with crystal on
  task automatic t_ext;
    logic [7:0] cfg;
    for (int i = 0; i < 2; i++) begin
      cfg = i ? 8'h0B : 8'h07;
      apb(1, TMRB_OFS_COUNT_LOW, 0, 0);
      apb(1, TMRB_OFS_CONTROL, {24'h0, cfg}, 0);
      portDir <= i ? 2'b10 : 2'b01;
      portData <= i ? 2'b01 : 2'b10;
      srcRun <= 1'b1;
      repeat (160) @(posedge clk);
      check({30'h0, pinOeN}, cfg[3] ? 32'h3 : {30'h0, portDir});
      check({30'h0, pinOut}, {30'h0, portData});
      check({31'h0, oscAmpEnable}, {31'h0, cfg[3]});
      srcRun <= 1'b0;
      repeat (10) @(posedge clk);
      apb(0, TMRB_OFS_COUNT_LOW, 0, 0);
      check(32'(rd >= 19 && rd <= 21), 32'h1);
      apb(1, TMRB_OFS_CONTROL, 0, 0);
    end
  endtask : t_ext
  // buffered wide access, then a wrap with the flag enabled
  task automatic t_wide;
    apb(1, TMRB_OFS_CONTROL, 32'h80, 0);
    apb(1, TMRB_OFS_COUNT_HIGH, 32'h12, 0);
    check({24'h0, countValue[15:8]}, 32'h0);
    apb(1, TMRB_OFS_COUNT_LOW, 32'h34, 0);
    check({16'h0, countValue}, 32'h1234);
    apb(0, TMRB_OFS_COUNT_HIGH, 0, 0);
    check(rd, 32'h12);
    apb(1, TMRB_OFS_COUNT_HIGH, 32'hFF, 0);
    apb(1, TMRB_OFS_COUNT_LOW, 32'hFC, 0);
    apb(1, TMRB_OFS_ENABLE, 32'h1, 0);
    apb(1, TMRB_OFS_CONTROL, 32'h81, 0);
    repeat (40) @(posedge clk);
    check({31'h0, overflowIrq}, 32'h1);
    apb(0, TMRB_OFS_FLAG, 0, 0);
    check(rd, 32'h1);
    // stop but stay wide: low read must refresh the buffer from the wrapped high byte
    apb(1, TMRB_OFS_CONTROL, 32'h80, 0);
    apb(0, TMRB_OFS_COUNT_LOW, 0, 0);
    apb(0, TMRB_OFS_COUNT_HIGH, 0, 0);
    check(rd, 32'h0);
    apb(1, TMRB_OFS_CONTROL, 0, 0);
    apb(1, TMRB_OFS_FLAG, 0, 0);
    check({31'h0, overflowIrq}, 32'h0);
  endtask : t_wide
  // compare trigger clears the count, sets no flag, loses to a write
  task automatic t_trigger;
    apb(1, TMRB_OFS_COUNT_HIGH, 32'h12, 0);
    apb(1, TMRB_OFS_COUNT_LOW, 32'h34, 0);
    check({16'h0, countValue}, 32'h1234);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    @(posedge clk);
    check({16'h0, countValue}, 32'h0);
    check({31'h0, overflowIrq}, 32'h0);
    apb(1, TMRB_OFS_COUNT_LOW, 32'h55, 1);
    check({24'h0, countValue[7:0]}, 32'h55);
  endtask : t_trigger
  // hang guard, far above the roughly 1730 cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles > 8000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_timer;
    t_ext;
    t_wide;
    t_trigger;
    tally_and_finish;
  end
endmodule : tmrb_timer_counter_tb
